// File: rtl/ucaf_defines.svh
// Register offsets, field positions, reset values and timing counts
// Assumes a 10 MHz core clock and APB byte addressing
`ifndef UCAF_DEFINES_SVH
`define UCAF_DEFINES_SVH
`define UCAF_OFF_CONTROL      12'h000
`define UCAF_OFF_ADDRESS      12'h004
`define UCAF_OFF_FRAME_LOW    12'h008
`define UCAF_OFF_FRAME_HIGH   12'h00C
`define UCAF_OFF_MODE         12'h010
`define UCAF_CTL_ENABLE       0
`define UCAF_CTL_PPRST        1
`define UCAF_CTL_RESUME       2
`define UCAF_CTL_HOST_ENABLE       3
`define UCAF_CTL_TOKEN_BUSY_FLAG      5
`define UCAF_ADDR_LSPD        7
`define UCAF_RST_BYTE         8'h00
`define UCAF_SOF_PERIOD_NS    1000000
`define UCAF_CLK_PERIOD_NS    100
`define UCAF_SOF_CYCLES       (`UCAF_SOF_PERIOD_NS / `UCAF_CLK_PERIOD_NS)
`define UCAF_EOP_CYCLES       2
`define UCAF_TOKEN_CYCLES     32
`endif

// File: rtl/ucaf_pkg.sv
// Types shared by the control and frame block
// Assumes the defines header is compiled alongside
package ucaf_pkg;
	typedef enum logic [1:0] {
		UCAF_RES_IDLE = 2'b00,
		UCAF_RES_DRIVE = 2'b01,
		UCAF_RES_EOP = 2'b10
	} ucaf_res_t;
endpackage : ucaf_pkg

// File: rtl/ucaf_frame_store.sv
// Frame number store, loaded on each received start-of-frame
// Assumes a same-clock load strobe
`timescale 1ns/1ps
`default_nettype none
module ucaf_frame_store #(
	parameter int FW = 11
) (
	// Clock and reset
	input  wire logic          core_clk,
	input  wire logic          sys_rst,
	// Load side
	input  wire logic          load,
	input  wire logic [FW-1:0] frame_in,
	// Read side
	output logic      [FW-1:0] frame_q
);
	// Cleared at reset, updated only by the link
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			frame_q <= '0;
		else if (load)
			frame_q <= frame_in; // RQ12
	end
endmodule : ucaf_frame_store
`default_nettype wire

// File: rtl/ucaf_regs.sv
// Control, address and frame-number registers of a USB OTG controller
// Assumes an APB master on core_clk and a packet engine on the same clock
// Behaviour
// RQ1: ping-pong reset returns pointers to even bank
// RQ2: device mode bit zero enables the module
// RQ3: host mode bit zero sends SOF each ms
// RQ4: software checks token busy before new token
// RQ5: host enable toggle resets host logic
// RQ6: software holds resume 10 or 25 ms
// RQ7: host resume release appends low-speed EOP
// RQ8: low-speed select sets next token speed
// RQ9: seven-bit address, read-write, resets zero
// RQ10: frame low register shows bits 7:0
// RQ11: frame high register shows bits 10:8
// RQ12: received SOF loads frame registers
// RQ13: unimplemented upper bits read zero
// RQ14: token busy high while token executes
// RQ15: resume bit drives resume signalling
// RQ16: frame registers ignore writes, reset zero
`timescale 1ns/1ps
`default_nettype none
`include "ucaf_defines.svh"
module ucaf_regs #(
	parameter int SOF_CYCLES = `UCAF_SOF_CYCLES,
	parameter int FW         = 11
) (
	// Clock and reset
	input  wire logic          core_clk,
	input  wire logic          sys_rst,
	// APB slave
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [11:0]   paddr,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	// Packet engine side
	input  wire logic          token_start,
	input  wire logic          token_done,
	input  wire logic          sof_rx,
	input  wire logic [FW-1:0] sof_rx_frame,
	// Controls toward the engine
	output logic               module_enable,
	output logic               sof_generation_enable,
	output logic               pingpong_pointer_reset,
	output logic               host_logic_reset,
	output logic               sof_tx,
	output logic [FW-1:0]      sof_tx_frame,
	output logic               resume_drive,
	output logic               ls_eop_drive,
	output logic               low_speed_select,
	output logic [6:0]         device_address_field
);
	// Control register state
	logic          host_mode_r;
	logic          host_enable_r;
	logic          resume_r;
	logic          token_busy_flag;
	// Timers and the resume sequencer
	logic [$clog2(SOF_CYCLES+1)-1:0] sof_cnt_r;
	logic [$clog2(`UCAF_EOP_CYCLES+1)-1:0] eop_cnt_r;
	ucaf_pkg::ucaf_res_t res_state_r;
	logic [FW-1:0] frame_q;
	// Bus decode
	logic          wr_en;
	logic          rd_en;
	logic          ctl_bit0;
	logic          wr_ctl;
	logic          wr_adr;
	logic          wr_mode;

	// Write hit at one offset; the same compare serves the control, address and mode registers
	function automatic logic wr_hit(
		input logic        wr,
		input logic [11:0] a,
		input logic [11:0] off
	);
		return wr && (a == off);
	endfunction : wr_hit

	// Only the five word offsets answer; anything else is an error
	function automatic logic addr_mapped(
		input logic [11:0] a
	);
		return a inside {`UCAF_OFF_CONTROL, `UCAF_OFF_ADDRESS, `UCAF_OFF_FRAME_LOW,
			`UCAF_OFF_FRAME_HIGH, `UCAF_OFF_MODE};
	endfunction : addr_mapped

	// Control byte as software reads it
	function automatic logic [7:0] ctl_byte(
		input logic busy,
		input logic hen,
		input logic res,
		input logic ppr,
		input logic bit0
	);
		return {2'b00, busy, 1'b0, hen, res, ppr, bit0};
	endfunction : ctl_byte

	// Single-cycle access: answer in the access phase, never wait
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;
	assign ctl_bit0 = host_mode_r ? sof_generation_enable : module_enable;

	// Write strobes; the frame pair has none, so writes there are dropped
	assign wr_ctl  = wr_hit(wr_en, paddr, `UCAF_OFF_CONTROL);
	assign wr_adr  = wr_hit(wr_en, paddr, `UCAF_OFF_ADDRESS);
	assign wr_mode = wr_hit(wr_en, paddr, `UCAF_OFF_MODE); // RQ16

	// Frame number register pair, read-only to software
	ucaf_frame_store #(
		.FW (FW)
	) u_frame (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.load     (sof_rx),
		.frame_in (sof_rx_frame),
		.frame_q  (frame_q)
	); // RQ16

	// Bus handshake outputs straight from flops
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			// Zero wait states: ready follows every setup cycle
			pready  <= psel && !penable;
			// Error rides with ready so the master sees both together
			pslverr <= psel && !penable && !addr_mapped(paddr);
		end
	end

	// Read data prepared in setup so it is valid in access
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			prdata <= 32'h0000_0000;
		else if (rd_en)
		begin
			prdata <= 32'h0000_0000; // RQ13
			unique case (paddr)
				`UCAF_OFF_CONTROL:
					prdata[7:0] <= ctl_byte(token_busy_flag, host_enable_r, resume_r,
						pingpong_pointer_reset, ctl_bit0); // RQ14
				`UCAF_OFF_ADDRESS:
					prdata[7:0] <= {low_speed_select, device_address_field}; // RQ9
				`UCAF_OFF_FRAME_LOW:
					prdata[7:0] <= frame_q[7:0]; // RQ10
				`UCAF_OFF_FRAME_HIGH:
					prdata[2:0] <= frame_q[FW-1:8]; // RQ11
				`UCAF_OFF_MODE:
					prdata[0] <= host_mode_r;
				default:
					prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Role select, chosen by software
	// It decides what bit zero of the control register means
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			host_mode_r <= 1'b0;
		else if (wr_mode)
			host_mode_r <= pwdata[0];
	end

	// Bit zero means enable in device mode, SOF enable in host mode
	// The unselected role's bit keeps its value until that role returns
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			module_enable         <= 1'b0;
			sof_generation_enable <= 1'b0;
		end
		else if (wr_ctl)
		begin
			if (host_mode_r)
				sof_generation_enable <= pwdata[`UCAF_CTL_ENABLE]; // RQ3
			else
				module_enable <= pwdata[`UCAF_CTL_ENABLE]; // RQ2
		end
	end

	// Ping-pong reset level, held while software keeps it set
	// A level, not a pulse: pointers stay even until it is cleared
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			pingpong_pointer_reset <= 1'b0;
		else if (wr_ctl)
			pingpong_pointer_reset <= pwdata[`UCAF_CTL_PPRST]; // RQ1
	end

	// Host enable; any change pulses the host logic reset
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			host_enable_r    <= 1'b0;
			host_logic_reset <= 1'b0;
		end
		else
		begin
			host_logic_reset <= 1'b0;
			// Old value compared, so rewriting the same bit stays quiet
			if (wr_ctl)
			begin
				host_enable_r    <= pwdata[`UCAF_CTL_HOST_ENABLE];
				host_logic_reset <= pwdata[`UCAF_CTL_HOST_ENABLE] != host_enable_r; // RQ5
			end
		end
	end

	// Resume bit; software owns its duration
	// No timer here: a short hold gives a short resume on the bus
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			resume_r <= 1'b0;
		else if (wr_ctl)
			resume_r <= pwdata[`UCAF_CTL_RESUME]; // RQ6
	end

	// Resume drive, then low-speed EOP on release in host mode
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			res_state_r  <= ucaf_pkg::UCAF_RES_IDLE;
			eop_cnt_r    <= '0;
			resume_drive <= 1'b0;
			ls_eop_drive <= 1'b0;
		end
		else
		begin
			unique case (res_state_r)
				// Waiting for software to raise resume
				ucaf_pkg::UCAF_RES_IDLE:
				begin
					if (resume_r)
					begin
						res_state_r  <= ucaf_pkg::UCAF_RES_DRIVE;
						resume_drive <= 1'b1; // RQ15
					end
				end
				// Driving resume until software lets go
				ucaf_pkg::UCAF_RES_DRIVE:
				begin
					if (!resume_r)
					begin
						resume_drive <= 1'b0; // RQ15
						if (host_mode_r)
						begin
							res_state_r  <= ucaf_pkg::UCAF_RES_EOP;
							ls_eop_drive <= 1'b1; // RQ7
							eop_cnt_r    <= '0;
						end
						else
							res_state_r <= ucaf_pkg::UCAF_RES_IDLE;
					end
				end
				// Fixed low-speed tail; resume requests wait until it ends
				ucaf_pkg::UCAF_RES_EOP:
				begin
					eop_cnt_r <= eop_cnt_r + 1'b1;
					if (eop_cnt_r == ($bits(eop_cnt_r))'(`UCAF_EOP_CYCLES - 1))
					begin
						ls_eop_drive <= 1'b0;
						res_state_r  <= ucaf_pkg::UCAF_RES_IDLE;
					end
				end
				default:
					res_state_r <= ucaf_pkg::UCAF_RES_IDLE;
			endcase
		end
	end

	// Address and low-speed select
	// Speed choice is a level the engine reads when the next token starts
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			device_address_field <= 7'h00; // RQ9
			low_speed_select     <= 1'b0;
		end
		else if (wr_adr)
		begin
			device_address_field <= pwdata[6:0]; // RQ9
			low_speed_select     <= pwdata[`UCAF_ADDR_LSPD]; // RQ8
		end
	end

	// Token busy: start wins over done in the same cycle
	// Leaving host mode or a host reset drops a token in flight
	always_ff @(posedge core_clk)
	begin
		if (sys_rst || host_logic_reset || !host_mode_r)
			token_busy_flag <= 1'b0;
		else if (token_start)
			token_busy_flag <= 1'b1; // RQ14
		else if (token_done)
			token_busy_flag <= 1'b0; // RQ14
	end

	// SOF timer; one token per 1 ms while enabled in host mode
	// Restarts whenever generation is off, so the first SOF is a full period late
	// Period is a parameter; the default assumes the 10 MHz core clock
	always_ff @(posedge core_clk)
	begin
		if (sys_rst || host_logic_reset || !(host_mode_r && sof_generation_enable))
		begin
			sof_cnt_r    <= '0;
			sof_tx       <= 1'b0;
		end
		else if (sof_cnt_r == ($bits(sof_cnt_r))'(SOF_CYCLES - 1))
		begin
			sof_cnt_r <= '0;
			sof_tx    <= 1'b1; // RQ3
		end
		else
		begin
			sof_cnt_r <= sof_cnt_r + 1'b1;
			sof_tx    <= 1'b0;
		end
	end

	// Frame number sent with each generated SOF
	// Wraps at the frame width, as the bus frame count does
	always_ff @(posedge core_clk)
	begin
		if (sys_rst || host_logic_reset)
			sof_tx_frame <= '0;
		else if (sof_tx)
			sof_tx_frame <= sof_tx_frame + 1'b1;
	end
endmodule : ucaf_regs
`default_nettype wire

// File: tb/ucaf_regs_asserts.sv
// Port checks for the control, address and frame registers
// Assumes binding onto ucaf_regs, one clock domain
`timescale 1ns/1ps
`default_nettype none
module ucaf_regs_asserts (
	// Clock, reset and bus
	input wire logic        core_clk,
	input wire logic        sys_rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Controls
	input wire logic        module_enable,
	input wire logic        sof_generation_enable,
	input wire logic        pingpong_pointer_reset,
	input wire logic        host_logic_reset,
	input wire logic        resume_drive,
	input wire logic        ls_eop_drive,
	input wire logic        low_speed_select,
	input wire logic [6:0]  device_address_field
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	logic wr_ctl;
	logic wr_adr;
	logic hen_r;
	logic wr_mode;
	logic mode_r;
	// Writes take effect only at the ready edge
	assign wr_ctl = psel && penable && pwrite && pready && paddr == 12'h000;
	assign wr_adr = psel && penable && pwrite && pready && paddr == 12'h004;
	assign wr_mode = psel && penable && pwrite && pready && paddr == 12'h010;
	// Last written host enable, to spot toggles
	always_ff @(posedge core_clk)
		if (sys_rst)
			hen_r <= 1'b0;
		else if (wr_ctl)
			hen_r <= pwdata[3];
	// Last written role, to know what bit zero means
	always_ff @(posedge core_clk)
		if (sys_rst)
			mode_r <= 1'b0;
		else if (wr_mode)
			mode_r <= pwdata[0];
	property p_ready;
		psel && !penable |=> pready;
	endproperty
	a_ready: assert property (p_ready) else $error("no ready after setup");
	property p_hi;
		pready && !pwrite |-> prdata[31:8] == 24'h0;
	endproperty
	a_hi: assert property (p_hi) else $error("upper read bits set");
	property p_err;
		pslverr |-> pready && (pwrite || prdata == 32'h0);
	endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_ppr;
		wr_ctl |=> pingpong_pointer_reset == $past(pwdata[1]);
	endproperty
	a_ppr: assert property (p_ppr) else $error("pointer reset wrong");
	property p_en;
		wr_ctl && !mode_r |=> module_enable == $past(pwdata[0]);
	endproperty
	a_en: assert property (p_en) else $error("enable bit wrong");
	property p_sof;
		wr_ctl && mode_r |=> sof_generation_enable == $past(pwdata[0]);
	endproperty
	a_sof: assert property (p_sof) else $error("sof enable bit wrong");
	property p_hlr;
		wr_ctl && pwdata[3] != hen_r |-> ##[1:2] host_logic_reset;
	endproperty
	a_hlr: assert property (p_hlr) else $error("no host reset");
	property p_res;
		wr_ctl |-> ##2 resume_drive == $past(pwdata[2], 2);
	endproperty
	a_res: assert property (p_res) else $error("resume drive wrong");
	property p_eop;
		$rose(ls_eop_drive) |-> ls_eop_drive[*2] ##1 !ls_eop_drive;
	endproperty
	a_eop: assert property (p_eop) else $error("eop length wrong");
	property p_adr;
		wr_adr |=> {low_speed_select, device_address_field} == $past(pwdata[7:0]);
	endproperty
	a_adr: assert property (p_adr) else $error("address wrong");
endmodule : ucaf_regs_asserts
bind ucaf_regs ucaf_regs_asserts u_ucaf_regs_asserts (.core_clk, .sys_rst, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .module_enable,
	.sof_generation_enable, .pingpong_pointer_reset, .host_logic_reset, .resume_drive,
	.ls_eop_drive, .low_speed_select, .device_address_field);
`default_nettype wire

// File: tb/ucaf_engine_model.sv
// Packet engine stand-in: received SOF and token start/done pulses
// Assumes commands from the bench on core_clk
`timescale 1ns/1ps
`default_nettype none
module ucaf_engine_model (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	// Bench commands
	input  wire logic        sof_req,
	input  wire logic [10:0] sof_frame,
	input  wire logic        tok_req,
	input  wire logic [3:0]  tok_len,
	// Engine side of the block
	output logic             sof_rx,
	output logic      [10:0] sof_rx_frame,
	output logic             token_start,
	output logic             token_done
);
	logic [3:0] left_r;
	// Frame toggles outside the pulse, so a stale capture shows
	always_ff @(posedge core_clk)
	begin
		sof_rx       <= sof_req && !sys_rst;
		sof_rx_frame <= (sof_req || sys_rst) ? sof_frame : ~sof_rx_frame;
	end
	// Token lasts tok_len cycles; a long one models a slow bus
	always_ff @(posedge core_clk)
	begin
		token_start <= tok_req && !sys_rst;
		token_done  <= left_r == 4'd1;
		left_r      <= sys_rst ? 4'd0 : tok_req ? tok_len : (left_r != 4'd0 ? left_r - 4'd1 : 4'd0);
	end
endmodule : ucaf_engine_model
`default_nettype wire

// File: tb/ucaf_regs_bench.sv
// Self-checking bench for the control, address and frame registers
// Assumes the engine model and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module ucaf_regs_bench;
	localparam int SOFC = 20;
	logic        core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, d;
	logic [32:0] exp_q[$], e;
	logic [10:0] sof_frame = 0, sof_rx_frame, sof_tx_frame, fr;
	logic [6:0]  device_address_field;
	logic        pready, pslverr, token_start, token_done, sof_rx, sof_req = 0, tok_req = 0;
	logic        module_enable, sof_generation_enable, pingpong_pointer_reset, sof_tx;
	logic        host_logic_reset, resume_drive, ls_eop_drive, low_speed_select;
	integer      fails = 0, total_checks = 0, seed = 32'ha84686a4, k;
	ucaf_regs #(.SOF_CYCLES(SOFC)) u_ucaf_regs (.core_clk, .sys_rst, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .token_start, .token_done,
		.sof_rx, .sof_rx_frame, .module_enable, .sof_generation_enable,
		.pingpong_pointer_reset, .host_logic_reset, .sof_tx, .sof_tx_frame, .resume_drive,
		.ls_eop_drive, .low_speed_select, .device_address_field);
	ucaf_engine_model u_ucaf_engine_model (.core_clk, .sys_rst, .sof_req, .sof_frame,
		.tok_req, .tok_len(4'd8), .sof_rx, .sof_rx_frame, .token_start, .token_done);
	initial forever #50 core_clk = ~core_clk;
	task final_report;
		if (fails == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report
	// One APB transfer; a read leaves its expected {error, data} note
	task bus(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [32:0] x);
		@(posedge core_clk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd;
		if (!w)
			exp_q.push_back(x);
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : bus
	// Read results are matched against the oldest note
	always @(posedge core_clk)
		if (psel && penable && pready && !pwrite)
		begin
			e = exp_q.pop_front();
			`CHK({pslverr, prdata}, e)
		end
	// Cut a hang short
	initial
	begin
		repeat (3000) @(posedge core_clk);
		fails++;
		final_report;
	end
	initial
	begin
		repeat (16) @(posedge core_clk);
		sys_rst <= 1'b0;
		bus(1, 12'h008, 32'h0000_00ff, 0);
		for (int i = 0; i < 16; i += 4) bus(0, 12'(i), 0, 0);
		repeat (4)
		begin
			d = $random(seed);
			bus(1, 12'h004, d, 0);
			bus(0, 12'h004, 0, 33'(d[7:0]));
		end
		bus(0, 12'h014, 0, {1'b1, 32'h0});
		// Received frame lands split over both registers
		fr = 11'($random(seed));
		@(posedge core_clk) sof_req <= 1'b1;
		sof_frame <= fr;
		@(posedge core_clk) sof_req <= 1'b0;
		bus(0, 12'h008, 0, 33'(fr[7:0]));
		bus(0, 12'h00c, 0, 33'(fr[10:8]));
		bus(1, 12'h000, 32'h0000_0003, 0);
		#1 `CHK({module_enable, pingpong_pointer_reset}, 2'b11)
		// Host mode: measure the SOF spacing
		bus(1, 12'h010, 32'h0000_0001, 0);
		bus(1, 12'h000, 32'h0000_0009, 0);
		for (k = 0; k < 100 && !sof_tx; k++) @(posedge core_clk);
		k = 0;
		do begin @(posedge core_clk); k++; end while (!sof_tx && k < 100);
		`CHK(k, SOFC)
		`CHK(sof_tx_frame, 11'd1)
		// Busy while a token runs, clear before the next one
		repeat (2)
		begin
			@(posedge core_clk) tok_req <= 1'b1;
			@(posedge core_clk) tok_req <= 1'b0;
			repeat (2) @(posedge core_clk);
			bus(0, 12'h000, 0, 33'h29);
			for (k = 0; k < 20 && !token_done; k++) @(posedge core_clk);
			bus(0, 12'h000, 0, 33'h09);
		end
		// Resume held a scaled span, then the low-speed tail
		bus(1, 12'h000, 32'h0000_000d, 0);
		repeat (2) @(negedge core_clk);
		`CHK(resume_drive, 1'b1)
		repeat (25) @(posedge core_clk);
		bus(1, 12'h000, 32'h0000_0009, 0);
		for (k = 0; k < 10 && !ls_eop_drive; k++) @(posedge core_clk);
		`CHK(ls_eop_drive, 1'b1)
		`CHK(resume_drive, 1'b0)
		bus(1, 12'h000, 0, 0);
		repeat (4) @(posedge core_clk);
		final_report;
	end
endmodule : ucaf_regs_bench
`default_nettype wire
